//--- logic/dpsm_master.sv
// two-wire master that drives the dual pot serial slave port
// Contract
// RULE_01 - start: sda falls while scl high
// RULE_02 - stop: sda rises while scl high
// RULE_03 - repeated start signalled like a start
// RULE_04 - sda changes only while scl low
// RULE_05 - slave drives read bits after scl fall
// RULE_06 - master releases sda, makes every scl
// RULE_07 - ninth bit is acknowledge, zero acknowledges
// RULE_08 - bytes eight bits, msb first, then ack
// RULE_09 - master acks more, nacks the last
// RULE_10 - address 0101 then three strap levels
// RULE_11 - first byte address plus direction bit
// RULE_12 - unmatched slave stays off sda
// RULE_13 - write: start, address, data, stop; check acks
// RULE_14 - several data bytes per write
// RULE_15 - poll address while nonvolatile write runs
// RULE_16 - nonvolatile update stores all three bytes
// RULE_17 - zero crossing delays nonvolatile write
// RULE_18 - single byte read returns wiper 0
// RULE_19 - reads cycle wiper0, wiper1, configuration
// RULE_20 - idle bus: both lines released high
// RULE_21 - slave listens only while enable low
// RULE_22 - stop launches nonvolatile write
// RULE_23 - bytes tagged 10 go to configuration
// RULE_24 - configuration bits: storage, zero cross, positions
// RULE_25 - every start resets slave transaction state
`timescale 1ns/1ns
module dpsm_master (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // user command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic [1:0] cmd_count,
   input wire logic [7:0] cmd_data0,
   input wire logic [7:0] cmd_data1,
   input wire logic [7:0] cmd_data2,
   input wire logic cmd_poll,
   // user result port
   output logic rsp_valid,
   output logic rsp_nack,
   output logic [7:0] rsp_data0,
   output logic [7:0] rsp_data1,
   output logic [7:0] rsp_data2,
   // slave select straps and enable
   input wire logic [2:0] addr_strap,
   output logic comm_enable_n,
   // two-wire bus, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   import dpsm_pkg::*;
   typedef enum logic [2:0] {
      dpsm_st_idle = 3'h0,
      dpsm_st_start = 3'h1,
      dpsm_st_addr = 3'h2,
      dpsm_st_wdata = 3'h3,
      dpsm_st_rdata = 3'h4,
      dpsm_st_stop = 3'h5,
      dpsm_st_report = 3'h6
   } dpsm_state_type;
   dpsm_state_type state;
   dpsm_bit_if bi ();
   logic sda_sync;
   logic scl_sync;
   logic [1:0] index;
   logic is_read;
   logic poll;
   logic nacked;
   logic [1:0] count;
   logic [7:0] wbuf [0:2];
   logic [7:0] rbuf [0:2];
   logic [1:0] last;
   // ****************************************
   // pin synchronisers
   // ****************************************
   dpsm_sync u_sda_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .d(sda_i),
      .q(sda_sync)
   );
   dpsm_sync u_scl_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .d(scl_i),
      .q(scl_sync)
   );
   // ****************************************
   // bit engine
   // ****************************************
   dpsm_bit_engine u_eng (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .bi(bi.eng),
      .sda_sync(sda_sync),
      .scl_o(scl_o),
      .scl_oe(scl_oe),
      .sda_o(sda_o),
      .sda_oe(sda_oe)
   );
   // slave is kept enabled while we own a transaction, disabled when idle with no command pending
   assign comm_enable_n = (state == dpsm_st_idle) && !cmd_valid; // RULE_21
   assign cmd_ready = (state == dpsm_st_idle);
   assign last = count - 2'h1;
   // ****************************************
   // requests toward the bit engine
   // ****************************************
   always_comb begin
      bi.req = 1'b0;
      bi.cmd = dpsm_cmd_idle;
      bi.wdata = 8'h00;
      bi.ack_out = 1'b1;
      if (!bi.busy && !bi.done) begin
         case (state)
            dpsm_st_start: begin
               bi.req = 1'b1;
               bi.cmd = dpsm_cmd_start;
            end
            dpsm_st_addr: begin
               bi.req = 1'b1;
               bi.cmd = dpsm_cmd_write;
               bi.wdata = {dpsm_addr_upper, addr_strap, is_read}; // RULE_10 RULE_11
            end
            dpsm_st_wdata: begin
               bi.req = 1'b1;
               bi.cmd = dpsm_cmd_write;
               bi.wdata = wbuf[index];
            end
            dpsm_st_rdata: begin
               bi.req = 1'b1;
               bi.cmd = dpsm_cmd_read;
               bi.ack_out = (index == last); // RULE_09
            end
            dpsm_st_stop: begin
               bi.req = 1'b1;
               bi.cmd = dpsm_cmd_stop;
            end
            default: bi.req = 1'b0;
         endcase
      end
   end
   // ****************************************
   // transaction sequencer
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= dpsm_st_idle;
         index <= 2'h0;
         is_read <= 1'b0;
         poll <= 1'b0;
         nacked <= 1'b0;
         count <= 2'h1;
      end else begin
         case (state)
            dpsm_st_idle: if (cmd_valid) begin
               is_read <= cmd_read;
               poll <= cmd_poll;
               count <= (cmd_count == 2'h0) ? 2'h1 : cmd_count;
               nacked <= 1'b0;
               index <= 2'h0;
               state <= dpsm_st_start;
            end
            dpsm_st_start: if (bi.done) begin
               state <= dpsm_st_addr; // RULE_25
            end
            dpsm_st_addr: if (bi.done) begin
               if (bi.ack_in) begin
                  // no answer: slave busy with its nonvolatile write or absent
                  if (poll) begin
                     state <= dpsm_st_start; // RULE_15 repeated start to poll
                  end else begin
                     nacked <= 1'b1; // RULE_12
                     state <= dpsm_st_stop;
                  end
               end else begin
                  state <= is_read ? dpsm_st_rdata : dpsm_st_wdata;
               end
            end
            dpsm_st_wdata: if (bi.done) begin
               index <= index + 2'h1;
               if (bi.ack_in) begin
                  nacked <= 1'b1; // RULE_13
                  state <= dpsm_st_stop;
               end else if (index == last) begin
                  state <= dpsm_st_stop; // RULE_14 RULE_22 stop launches storage
               end
            end
            dpsm_st_rdata: if (bi.done) begin
               index <= index + 2'h1;
               if (index == last) begin
                  state <= dpsm_st_stop;
               end
            end
            dpsm_st_stop: if (bi.done) begin
               state <= dpsm_st_report;
            end
            dpsm_st_report: state <= dpsm_st_idle;
            default: state <= dpsm_st_idle;
         endcase
      end
   end
   // ****************************************
   // write data capture
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wbuf[0] <= 8'h00;
         wbuf[1] <= 8'h00;
         wbuf[2] <= dpsm_cfg_reset;
      end else if (state == dpsm_st_idle && cmd_valid) begin
         wbuf[0] <= cmd_data0;
         wbuf[1] <= cmd_data1;
         wbuf[2] <= cmd_data2; // RULE_23 RULE_24 user tags the byte 10xxxxxx
      end
   end
   // ****************************************
   // read data, slot order wiper0, wiper1, configuration
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < dpsm_reads_per_cycle; g++) begin : g_rbuf
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               rbuf[g] <= 8'h00;
            end else if (state == dpsm_st_rdata && bi.done && index == 2'(g)) begin
               rbuf[g] <= bi.rdata; // RULE_18 RULE_19 RULE_05
            end
         end
      end
   endgenerate
   // ****************************************
   // result outputs
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rsp_valid <= 1'b0;
         rsp_nack <= 1'b0;
         rsp_data0 <= 8'h00;
         rsp_data1 <= 8'h00;
         rsp_data2 <= 8'h00;
      end else begin
         rsp_valid <= (state == dpsm_st_report);
         if (state == dpsm_st_report) begin
            rsp_nack <= nacked;
            rsp_data0 <= rbuf[0];
            rsp_data1 <= rbuf[1];
            rsp_data2 <= rbuf[2];
         end
      end
   end
   // scl is read back only to keep the pin sampled; no stretching is done
   logic scl_seen;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         scl_seen <= 1'b1;
      end else begin
         scl_seen <= scl_sync;
      end
   end
endmodule : dpsm_master

//--- logic/dpsm_pkg.sv
// package of constants and types for the dual pot serial master
package dpsm_pkg;
   // ****************************************
   // address and configuration layout
   // ****************************************
   localparam logic [3:0] dpsm_addr_upper = 4'h5;
   localparam logic dpsm_dir_write = 1'b0;
   localparam logic dpsm_dir_read = 1'b1;
   localparam logic [1:0] dpsm_cfg_tag = 2'h2;
   localparam int dpsm_cfg_storage_bit = 2;
   localparam int dpsm_cfg_zero_cross_bit = 1;
   localparam int dpsm_cfg_positions_bit = 0;
   localparam logic [7:0] dpsm_cfg_reset = 8'h87;
   localparam int dpsm_byte_bits = 8;
   localparam int dpsm_reads_per_cycle = 3;
   // ****************************************
   // timing
   // ****************************************
   localparam int dpsm_clk_mhz = 50;
   localparam int dpsm_half_period_ns = 2500;
   localparam int dpsm_half_cycles = (dpsm_half_period_ns * dpsm_clk_mhz) / 1000;
   localparam logic [7:0] dpsm_half_count = 8'(dpsm_half_cycles - 1);
   localparam int dpsm_nv_write_time_us = 10000;
   localparam int dpsm_nv_write_cycles = dpsm_nv_write_time_us * dpsm_clk_mhz;
   // ****************************************
   // command type
   // ****************************************
   typedef enum logic [2:0] {
      dpsm_cmd_start = 3'h0,
      dpsm_cmd_write = 3'h1,
      dpsm_cmd_read = 3'h2,
      dpsm_cmd_stop = 3'h3,
      dpsm_cmd_idle = 3'h4
   } dpsm_cmd_type;
endpackage : dpsm_pkg

//--- logic/dpsm_bit_if.sv
// interface between the byte sequencer and the bit engine
`timescale 1ns/1ns
interface dpsm_bit_if;
   import dpsm_pkg::*;
   logic req;
   dpsm_cmd_type cmd;
   logic [7:0] wdata;
   logic ack_out;
   logic busy;
   logic done;
   logic [7:0] rdata;
   logic ack_in;
   modport seq (output req, output cmd, output wdata, output ack_out,
      input busy, input done, input rdata, input ack_in);
   modport eng (input req, input cmd, input wdata, input ack_out,
      output busy, output done, output rdata, output ack_in);
endinterface : dpsm_bit_if

//--- logic/dpsm_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
module dpsm_sync (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // level in and out
   input wire logic d,
   output logic q
);
   logic meta;
   // ****************************************
   // two stage capture
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta <= 1'b1;
         q <= 1'b1;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : dpsm_sync

//--- logic/dpsm_bit_engine.sv
// bit engine: makes scl by division, start, stop and bytes on sda
`timescale 1ns/1ns
module dpsm_bit_engine (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // sequencer side
   dpsm_bit_if.eng bi,
   // bus pins, already synchronised sda in
   input wire logic sda_sync,
   output logic scl_o,
   output logic scl_oe,
   output logic sda_o,
   output logic sda_oe
);
   import dpsm_pkg::*;
   typedef enum logic [2:0] {
      dpsm_ph_idle = 3'h0,
      dpsm_ph_start = 3'h1,
      dpsm_ph_bit = 3'h2,
      dpsm_ph_stop = 3'h3,
      dpsm_ph_done = 3'h4
   } dpsm_phase_type;
   dpsm_phase_type phase;
   logic [7:0] tick;
   logic [1:0] quarter;
   logic [3:0] bitn;
   logic [8:0] shreg;
   logic scl_low;
   logic sda_low;
   logic is_read;
   logic tick_end;
   assign tick_end = (tick == dpsm_half_count);
   // open drain: only a low is driven
   assign scl_o = 1'b0;
   assign scl_oe = scl_low;
   assign sda_o = 1'b0;
   assign sda_oe = sda_low;
   assign bi.busy = (phase != dpsm_ph_idle);
   // ****************************************
   // sequencing of bits in four quarters
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         phase <= dpsm_ph_idle;
         tick <= 8'h00;
         quarter <= 2'h0;
         bitn <= 4'h0;
         shreg <= 9'h1ff;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         is_read <= 1'b0;
         bi.done <= 1'b0;
         bi.rdata <= 8'h00;
         bi.ack_in <= 1'b1;
      end else begin
         bi.done <= 1'b0;
         tick <= tick_end ? 8'h00 : tick + 8'h01;
         case (phase)
            dpsm_ph_idle: begin
               tick <= 8'h00;
               quarter <= 2'h0;
               if (bi.req) begin
                  bitn <= 4'h0;
                  is_read <= (bi.cmd == dpsm_cmd_read);
                  // read: release 8 bits, then drive our ack or nack
                  shreg <= (bi.cmd == dpsm_cmd_read) ? {8'hff, bi.ack_out}
                     : {bi.wdata, 1'b1}; // RULE_08 RULE_06
                  case (bi.cmd)
                     dpsm_cmd_start: phase <= dpsm_ph_start;
                     dpsm_cmd_stop: phase <= dpsm_ph_stop;
                     dpsm_cmd_write: phase <= dpsm_ph_bit;
                     dpsm_cmd_read: phase <= dpsm_ph_bit;
                     default: phase <= dpsm_ph_done;
                  endcase
               end
            end
            dpsm_ph_start: if (tick_end) begin
               // q0 release sda, q1 release scl, q2 pull sda with scl high, q3 pull scl
               quarter <= quarter + 2'h1;
               case (quarter)
                  2'h0: sda_low <= 1'b0;
                  2'h1: scl_low <= 1'b0;
                  2'h2: sda_low <= 1'b1; // RULE_01 RULE_03
                  default: begin
                     scl_low <= 1'b1;
                     phase <= dpsm_ph_done;
                  end
               endcase
            end
            dpsm_ph_stop: if (tick_end) begin
               quarter <= quarter + 2'h1;
               case (quarter)
                  2'h0: sda_low <= 1'b1;
                  2'h1: scl_low <= 1'b0;
                  2'h2: sda_low <= 1'b0; // RULE_02 RULE_20
                  default: phase <= dpsm_ph_done;
               endcase
            end
            dpsm_ph_bit: if (tick_end) begin
               quarter <= quarter + 2'h1;
               case (quarter)
                  2'h0: sda_low <= ~shreg[8]; // RULE_04 change only with scl low
                  2'h1: scl_low <= 1'b0;
                  2'h2: begin
                     // sample in the middle of the high phase
                     if (bitn == 4'h8) begin
                        bi.ack_in <= sda_sync; // RULE_07
                     end else begin
                        bi.rdata <= {bi.rdata[6:0], sda_sync};
                     end
                  end
                  default: begin
                     scl_low <= 1'b1;
                     shreg <= {shreg[7:0], 1'b1};
                     bitn <= bitn + 4'h1;
                     if (bitn == 4'h8) begin
                        // sda is held across the scl fall; a rise here would look like a stop
                        phase <= dpsm_ph_done; // RULE_04
                     end
                  end
               endcase
            end
            dpsm_ph_done: begin
               bi.done <= 1'b1;
               phase <= dpsm_ph_idle;
            end
            default: phase <= dpsm_ph_idle;
         endcase
      end
   end
endmodule : dpsm_bit_engine

//--- dv/dpsm_master_chk.sv
// port assertions for the two-wire master
`timescale 1ns/1ns
module dpsm_master_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // user side
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic rsp_nack,
   input wire logic comm_enable_n,
   // bus side
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ****************************************
   // bus conditions
   // ****************************************
   // sda pulled or released while scl is released
   sequence s_start;
      $rose(sda_oe) && !scl_oe;
   endsequence
   sequence s_stop;
      $fell(sda_oe) && !scl_oe;
   endsequence
   property p_start;
      s_start |-> sda_oe throughout (##[1:500] scl_oe);
   endproperty
   property p_stop;
      s_stop |-> (!scl_oe && !sda_oe) [*8];
   endproperty
   property p_hold_high;
      $fell(scl_oe) |-> $stable(sda_oe) [*8];
   endproperty
   property p_hold_fall;
      $rose(scl_oe) |-> $stable(sda_oe);
   endproperty
   property p_open_drain;
      scl_o == 1'b0 && sda_o == 1'b0;
   endproperty
   property p_idle;
      cmd_ready |-> !scl_oe && !sda_oe;
   endproperty
   property p_accept;
      cmd_valid && cmd_ready |=> !cmd_ready && !comm_enable_n;
   endproperty
   property p_enable;
      !cmd_ready |-> !comm_enable_n;
   endproperty
   property p_rsp;
      rsp_valid |=> !rsp_valid;
   endproperty
   property p_nack_hold;
      !rsp_valid |-> $stable(rsp_nack);
   endproperty
   a_start: assert property (p_start) else $error("start shape wrong");
   a_stop: assert property (p_stop) else $error("stop shape wrong");
   a_hold_high: assert property (p_hold_high) else $error("sda moved, scl high");
   a_hold_fall: assert property (p_hold_fall) else $error("sda moved at scl fall");
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   a_idle: assert property (p_idle) else $error("idle bus not released");
   a_accept: assert property (p_accept) else $error("command not taken");
   a_enable: assert property (p_enable) else $error("enable high in use");
   a_rsp: assert property (p_rsp) else $error("response not a pulse");
   a_nack_hold: assert property (p_nack_hold) else $error("nack moved");
endmodule : dpsm_master_chk
bind dpsm_master dpsm_master_chk dpsm_master_chk_i (.ref_clk, .rstn, .cmd_valid, .cmd_ready,
   .rsp_valid, .rsp_nack, .comm_enable_n, .scl_o, .scl_oe, .sda_o, .sda_oe);

//--- dv/dpsm_slave_model.sv
// behavioural model of the dual pot serial slave port
`timescale 1ns/1ns
module dpsm_slave_model #(
   parameter logic [2:0] strap = 3'h5,
   parameter int busy_ns = 120000,
   parameter int zc_ns = 20000
) (
   // bus lines and enable
   input wire logic scl,
   input wire logic sda,
   input wire logic enable_n,
   output logic sda_oe
);
   import dpsm_pkg::*;
   logic [7:0] w0 = 8'h00, w1 = 8'h00, cfg = dpsm_cfg_reset, nv0, nv1, nvc, sh, tx;
   logic act = 1'b0, rd = 1'b0, ackd = 1'b0, dirty = 1'b0, busy = 1'b0;
   int bitn = 0, ph = 0, idx = 0;
   event nv_go;
   initial sda_oe = 1'b0;
   // start or repeated start resets the transfer
   always @(negedge sda) begin
      if (scl && !enable_n) begin
         act = 1'b1;
         bitn = 0;
         ph = 0;
         idx = 0;
         ackd = 1'b0;
      end
   end
   // stop ends the transfer and may launch the stored write
   always @(posedge sda) begin
      if (scl && !enable_n) begin
         act = 1'b0;
         if (dirty && !cfg[dpsm_cfg_storage_bit]) ->nv_go;
         dirty = 1'b0;
      end
   end
   // sample on scl rise
   always @(posedge scl) begin
      if (act && !enable_n) begin
         if (bitn == 8 && ph == 2 && sda) act = 1'b0;
         if (bitn < 8) sh = {sh[6:0], sda};
         bitn = (bitn == 8) ? 0 : bitn + 1;
      end
   end
   // drive on scl fall
   always @(negedge scl) begin
      if (act && !enable_n) begin
         if (bitn == 8) begin
            ackd = 1'b1;
            sda_oe = (ph != 2);
            if (ph == 0) rd = (sh[0] == dpsm_dir_read);
            if (ph == 0 && (sh[7:1] != {dpsm_addr_upper, strap} || busy)) begin
               act = 1'b0;
               sda_oe = 1'b0;
            end
            if (ph == 1) begin
               dirty = 1'b1;
               if (sh[7:6] == dpsm_cfg_tag) cfg = sh;
               else if (sh[6]) w1 = sh;
               else w0 = sh;
            end
         end else if (bitn == 0 && ackd) begin
            ackd = 1'b0;
            sda_oe = 1'b0;
            if (ph == 0) ph = rd ? 2 : 1;
            if (ph == 2) begin
               tx = (idx == 0) ? w0 : (idx == 1) ? w1 : cfg;
               idx = (idx == 2) ? 0 : idx + 1;
            end
         end
         if (act && ph == 2 && bitn < 8 && !ackd) sda_oe = !tx[7 - bitn];
      end
   end
   // nonvolatile write of all three bytes
   always @(nv_go) begin
      busy = 1'b1;
      if (cfg[dpsm_cfg_zero_cross_bit]) #(zc_ns);
      {nv0, nv1, nvc} = {w0, w1, cfg};
      #(busy_ns);
      busy = 1'b0;
   end
endmodule : dpsm_slave_model

//--- dv/dpsm_master_tb.sv
// self-checking bench for the two-wire master
`timescale 1ns/1ns
module dpsm_master_tb;
   import dpsm_pkg::*;
   logic ref_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0, cmd_poll = 1'b0;
   logic [1:0] cmd_count = 2'h0;
   logic [7:0] cmd_data0 = 8'h00, cmd_data1 = 8'h00, cmd_data2 = 8'h00;
   logic [2:0] addr_strap = 3'h5;
   logic cmd_ready, rsp_valid, rsp_nack, comm_enable_n, scl_o, scl_oe, sda_o, sda_oe, s_oe;
   logic [7:0] rsp_data0, rsp_data1, rsp_data2;
   int fail_count = 0, num_checks = 0, cycles = 0;
   // open-drain lines with pull-ups
   wire scl_w = !scl_oe;
   wire sda_w = !(sda_oe || s_oe);
   dpsm_master dpsm_master_i (.ref_clk, .rstn, .cmd_valid, .cmd_ready, .cmd_read, .cmd_count,
      .cmd_data0, .cmd_data1, .cmd_data2, .cmd_poll, .rsp_valid, .rsp_nack, .rsp_data0,
      .rsp_data1, .rsp_data2, .addr_strap, .comm_enable_n, .scl_i(scl_w), .scl_o, .scl_oe,
      .sda_i(sda_w), .sda_o, .sda_oe);
   dpsm_slave_model dpsm_slave_model_i (.scl(scl_w), .sda(sda_w), .enable_n(comm_enable_n),
      .sda_oe(s_oe));
   // ****************************************
   // clock, timeout and tasks
   // ****************************************
   initial forever #10 ref_clk = !ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         fail_count = fail_count + 1;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // one command, held until taken, then wait for the response pulse
   task automatic xfer(input logic rd, input logic [1:0] n, input logic [7:0] d0,
         input logic [7:0] d1, input logic [7:0] d2, input logic poll, input logic [2:0] st);
      int k;
      @(posedge ref_clk);
      cmd_read <= rd;
      cmd_count <= n;
      cmd_data0 <= d0;
      cmd_data1 <= d1;
      cmd_data2 <= d2;
      cmd_poll <= poll;
      addr_strap <= st;
      cmd_valid <= 1'b1;
      // look at ready between edges, then drop valid just after the taking edge
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      k = 0;
      do begin
         @(negedge ref_clk);
         k = k + 1;
      end while (rsp_valid !== 1'b1 && k < 60000);
      chk("rsp_valid", 8'h01, rsp_valid);
   endtask : xfer
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge ref_clk);
      chk("cmd_ready", 8'h01, cmd_ready);
      chk("bus_oe", 8'h00, {scl_oe, sda_oe});
      rstn <= 1'b1;
      xfer(1'b0, 2'h3, 8'h05, 8'h4a, 8'h83, 1'b0, 3'h5);
      chk("nack_wr3", 8'h00, rsp_nack);
      xfer(1'b0, 2'h1, 8'h07, 8'h00, 8'h00, 1'b0, 3'h5);
      chk("nack_busy", 8'h01, rsp_nack);
      xfer(1'b0, 2'h1, 8'h07, 8'h00, 8'h00, 1'b1, 3'h5);
      chk("nack_poll", 8'h00, rsp_nack);
      xfer(1'b1, 2'h3, 8'h00, 8'h00, 8'h00, 1'b1, 3'h5);
      chk("rd0", 8'h07, rsp_data0);
      chk("rd1", 8'h4a, rsp_data1);
      chk("rd2", 8'h83, rsp_data2);
      chk("nv0", 8'h07, dpsm_slave_model_i.nv0);
      chk("nv1", 8'h4a, dpsm_slave_model_i.nv1);
      chk("nvc", 8'h83, dpsm_slave_model_i.nvc);
      xfer(1'b0, 2'h1, 8'h85, 8'h00, 8'h00, 1'b0, 3'h5);
      xfer(1'b0, 2'h1, 8'h0c, 8'h00, 8'h00, 1'b0, 3'h5);
      chk("nack_vol", 8'h00, rsp_nack);
      chk("nv_keep", 8'h07, dpsm_slave_model_i.nv0);
      xfer(1'b1, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 3'h5);
      chk("rd_one", 8'h0c, rsp_data0);
      chk("nack_rd", 8'h00, rsp_nack);
      xfer(1'b1, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 3'h7);
      chk("nack_addr", 8'h01, rsp_nack);
      stop_test();
   end
endmodule : dpsm_master_tb
